// ==== pkg/sdbp_pkg.sv ====
// Constants, carrier types and field layouts for the separate-I/O burst SRAM port.
// Assumes one link clock pair from the controller and one core clock for the write log.
// Function
// - Shared address bus, read/write slots alternate.
// - Each address moves a four-word burst.
// - Two words per link cycle, both ports.
// - Only rising link clock edges are used.
// - Latency pin high: data two cycles later.
// - Latency pin low: data one cycle later.
// - Valid strobe high exactly while data shown.
// - Complementary echo clocks accompany read data.
// - All pin inputs pass input registers.
// - Read data leaves through output registers.
// - Writes complete internally, no external pulse.
// - Deselected port takes no action at all.
// - Read and write ports run concurrently.
// - Read after write returns newest data.
package sdbp_pkg;

  localparam int WORD_W = 18;
  localparam int ADDR_W = 18;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = WORD_W * BURST_LEN;
  localparam int ARRAY_DEPTH = 2 ** ADDR_W;
  localparam int LOG_DEPTH = 32;

  // Read latency in link cycles for each setting of the latency pin.
  localparam int LAT_FULL_CYC = 2;
  localparam int LAT_ONE_CYC = 1;

  // Slot codes of the alternating address phase; the read slot comes first after reset.
  localparam logic SLOT_READ = 1'h0;
  localparam logic SLOT_WRITE = 1'h1;

  // Values after reset.
  localparam logic [WORD_W-1:0] RST_WORD = 18'h00000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 18'h00000;
  localparam logic [BURST_W-1:0] RST_BURST = 72'h000000000000000000;
  localparam logic RST_ECHO = 1'h0;

  // Registered copy of the controller's pins for one link cycle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [WORD_W-1:0] d_k;
    logic [WORD_W-1:0] d_kn;
  } sdbp_pin_s;

  // One committed write burst as recorded in the log.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BURST_W-1:0] data;
  } sdbp_log_s;

  localparam int LOG_W = $bits(sdbp_log_s);

endpackage

// ==== src/sdbp_fifo.sv ====
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
// Assumes DEPTH is a power of two; each side has its own synchronous reset.
`timescale 1ns/1ps
module sdbp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Filling side.
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  // Draining side.
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0] wbin_r;
  logic [AW:0] wbin_nxt;
  logic [AW:0] wgray_r;
  logic [AW:0] wgray_nxt;
  logic [AW:0] rbin_r;
  logic [AW:0] rbin_nxt;
  logic [AW:0] rgray_r;
  logic [AW:0] rgray_nxt;
  logic [AW:0] rgray_s;
  logic [AW:0] wgray_s;
  logic push;
  logic pop;

  sdbp_sync #(.W(AW + 1)) u_rptr_sync (
    .clk(wr_clk),
    .rst(wr_rst),
    .d(rgray_r),
    .q(rgray_s)
  );

  sdbp_sync #(.W(AW + 1)) u_wptr_sync (
    .clk(rd_clk),
    .rst(rd_rst),
    .d(wgray_r),
    .q(wgray_s)
  );

  // Full compares against a possibly stale read pointer, so it errs toward refusing.
  assign wr_ready = (wgray_r != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
  assign rd_valid = (rgray_r != wgray_s);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem[rbin_r[AW-1:0]];

  always_comb begin
    wbin_nxt = wbin_r + (AW + 1)'(push);
    wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
    if (wr_rst) begin
      wbin_nxt = '0;
      wgray_nxt = '0;
    end
  end

  always_comb begin
    rbin_nxt = rbin_r + (AW + 1)'(pop);
    rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
    if (rd_rst) begin
      rbin_nxt = '0;
      rgray_nxt = '0;
    end
  end

  always_ff @(posedge wr_clk) begin
    wbin_r <= wbin_nxt;
    wgray_r <= wgray_nxt;
    if (push) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    rbin_r <= rbin_nxt;
    rgray_r <= rgray_nxt;
  end

endmodule

// ==== src/sdbp_port.sv ====
// Link-side logic of the separate-I/O burst SRAM: pin registers, array, read pipeline
// and echo clocks, plus a write log handed to the core clock through a FIFO.
// Assumes the controller keeps the link clock running and the latency pin static.
`timescale 1ns/1ps
module sdbp_port
  import sdbp_pkg::*;
(
  // Core clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Link clock from the controller; its complementary edge is carried as a second lane.
  input wire logic link_clk,
  // Shared address bus and port selects, active low.
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  // Write data: word on the true edge and word on the complementary edge.
  input wire logic [WORD_W-1:0] wdata_k,
  input wire logic [WORD_W-1:0] wdata_kn,
  // Latency strap, high for the longer latency.
  input wire logic latency_select_pin,
  // Read data lanes, valid strobe and echo clocks.
  output logic [WORD_W-1:0] q_k,
  output logic [WORD_W-1:0] q_kn,
  output logic read_data_valid_out,
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  // Write log on the core clock; log_room comes from the link clock side.
  output logic log_valid,
  input wire logic log_ready,
  output logic [ADDR_W-1:0] log_addr,
  output logic [BURST_W-1:0] log_data,
  output logic log_room,
  output logic log_overflow
);

  logic lrst;
  logic lat_full;
  logic drop_s;

  logic [BURST_W-1:0] arr_mem [0:ARRAY_DEPTH-1];

  sdbp_pin_s pin_r;
  sdbp_pin_s pin_nxt;
  logic slot_r;
  logic slot_nxt;
  logic rd_fire;
  logic wr_fire;

  logic wpend_r;
  logic wpend_nxt;
  logic [ADDR_W-1:0] waddr_r;
  logic [ADDR_W-1:0] waddr_nxt;
  logic [2*WORD_W-1:0] wlo_r;
  logic [2*WORD_W-1:0] wlo_nxt;
  logic [BURST_W-1:0] wburst;

  logic [BURST_W-1:0] fetch;
  logic hold_v_r;
  logic hold_v_nxt;
  logic [BURST_W-1:0] hold_r;
  logic [BURST_W-1:0] hold_nxt;
  logic tail_v_r;
  logic tail_v_nxt;
  logic [2*WORD_W-1:0] tail_r;
  logic [2*WORD_W-1:0] tail_nxt;
  logic [WORD_W-1:0] qk_r;
  logic [WORD_W-1:0] qk_nxt;
  logic [WORD_W-1:0] qkn_r;
  logic [WORD_W-1:0] qkn_nxt;
  logic qv_r;
  logic qv_nxt;
  logic echo_r;
  logic echo_nxt;
  logic echo_n_r;
  logic echo_n_nxt;

  sdbp_log_s log_in;
  sdbp_log_s log_out;
  logic log_push_ready;
  logic drop_r;
  logic drop_nxt;

  // The link side gets its own reset and latency setting through synchronisers.
  sdbp_sync #(.W(1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'h0),
    .d(srst),
    .q(lrst)
  );

  sdbp_sync #(.W(1)) u_lat_sync (
    .clk(link_clk),
    .rst(lrst),
    .d(latency_select_pin),
    .q(lat_full)
  );

  sdbp_sync #(.W(1)) u_drop_sync (
    .clk(clk),
    .rst(srst),
    .d(drop_r),
    .q(drop_s)
  );

  // Input registers and the alternating address slot.
  always_comb begin
    pin_nxt.addr = addr_in;
    pin_nxt.rd_sel_n = rd_sel_n;
    pin_nxt.wr_sel_n = wr_sel_n;
    pin_nxt.d_k = wdata_k;
    pin_nxt.d_kn = wdata_kn;
    slot_nxt = ~slot_r;
    if (lrst) begin
      pin_nxt.addr = RST_ADDR;
      pin_nxt.rd_sel_n = 1'h1;
      pin_nxt.wr_sel_n = 1'h1;
      pin_nxt.d_k = RST_WORD;
      pin_nxt.d_kn = RST_WORD;
      slot_nxt = SLOT_READ;
    end
  end

  always_ff @(posedge link_clk) begin
    pin_r <= pin_nxt;
    slot_r <= slot_nxt;
  end

  // A port whose select is high does nothing, so devices can share the buses.
  assign rd_fire = !pin_r.rd_sel_n && (slot_r == SLOT_READ);
  assign wr_fire = !pin_r.wr_sel_n && (slot_r == SLOT_WRITE);

  // Write path: two words with the address, two in the next cycle, then commit.
  assign wburst = {pin_r.d_kn, pin_r.d_k, wlo_r};

  always_comb begin
    wpend_nxt = wr_fire;
    waddr_nxt = waddr_r;
    wlo_nxt = wlo_r;
    if (wr_fire) begin
      waddr_nxt = pin_r.addr;
      wlo_nxt = {pin_r.d_kn, pin_r.d_k};
    end
    if (lrst) begin
      wpend_nxt = 1'h0;
      waddr_nxt = RST_ADDR;
      wlo_nxt = '0;
    end
  end

  // The array write is strobed from the link clock alone; no pulse comes from outside.
  always_ff @(posedge link_clk) begin
    wpend_r <= wpend_nxt;
    waddr_r <= waddr_nxt;
    wlo_r <= wlo_nxt;
    if (wpend_r) begin
      arr_mem[waddr_r] <= wburst;
    end
  end

  // A commit lands in the read slot, so a read of the same address takes the new burst.
  assign fetch = (wpend_r && (waddr_r == pin_r.addr)) ? wburst : arr_mem[pin_r.addr];

  // Read pipeline: one cycle of hold in the long latency mode, then two output beats.
  always_comb begin
    hold_v_nxt = rd_fire && lat_full;
    hold_nxt = rd_fire ? fetch : hold_r;
    tail_v_nxt = 1'h0;
    tail_nxt = tail_r;
    qk_nxt = qk_r;
    qkn_nxt = qkn_r;
    qv_nxt = 1'h0;
    if (tail_v_r) begin
      qk_nxt = tail_r[WORD_W-1:0];
      qkn_nxt = tail_r[2*WORD_W-1:WORD_W];
      qv_nxt = 1'h1;
    end else if (lat_full && hold_v_r) begin
      qk_nxt = hold_r[WORD_W-1:0];
      qkn_nxt = hold_r[2*WORD_W-1:WORD_W];
      tail_nxt = hold_r[BURST_W-1:2*WORD_W];
      tail_v_nxt = 1'h1;
      qv_nxt = 1'h1;
    end else if (!lat_full && rd_fire) begin
      qk_nxt = fetch[WORD_W-1:0];
      qkn_nxt = fetch[2*WORD_W-1:WORD_W];
      tail_nxt = fetch[BURST_W-1:2*WORD_W];
      tail_v_nxt = 1'h1;
      qv_nxt = 1'h1;
    end
    echo_nxt = ~echo_r;
    echo_n_nxt = echo_r;
    if (lrst) begin
      hold_v_nxt = 1'h0;
      hold_nxt = RST_BURST;
      tail_v_nxt = 1'h0;
      tail_nxt = '0;
      qk_nxt = RST_WORD;
      qkn_nxt = RST_WORD;
      qv_nxt = 1'h0;
      echo_nxt = RST_ECHO;
      echo_n_nxt = ~RST_ECHO;
    end
  end

  always_ff @(posedge link_clk) begin
    hold_v_r <= hold_v_nxt;
    hold_r <= hold_nxt;
    tail_v_r <= tail_v_nxt;
    tail_r <= tail_nxt;
    qk_r <= qk_nxt;
    qkn_r <= qkn_nxt;
    qv_r <= qv_nxt;
    echo_r <= echo_nxt;
    echo_n_r <= echo_n_nxt;
  end

  assign q_k = qk_r;
  assign q_kn = qkn_r;
  assign read_data_valid_out = qv_r;
  assign echo_clock_out = echo_r;
  assign echo_clock_out_n = echo_n_r;

  // Write log: the controller cannot be stalled, so a full log drops the entry and flags it.
  assign log_in.addr = waddr_r;
  assign log_in.data = wburst;

  always_comb begin
    drop_nxt = drop_r || (wpend_r && !log_push_ready);
    if (lrst) begin
      drop_nxt = 1'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    drop_r <= drop_nxt;
  end

  sdbp_fifo #(.W(LOG_W), .DEPTH(LOG_DEPTH)) u_log_fifo (
    .wr_clk(link_clk),
    .wr_rst(lrst),
    .wr_valid(wpend_r),
    .wr_ready(log_push_ready),
    .wr_data(log_in),
    .rd_clk(clk),
    .rd_rst(srst),
    .rd_valid(log_valid),
    .rd_ready(log_ready),
    .rd_data(log_out)
  );

  assign log_addr = log_out.addr;
  assign log_data = log_out.data;
  assign log_room = log_push_ready;
  assign log_overflow = drop_s;

endmodule

// ==== src/sdbp_sync.sv ====
// Two-flop level synchroniser, parameterised in width.
// Assumes each bit is a level or a gray-coded value that changes one bit at a time.
`timescale 1ns/1ps
module sdbp_sync #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and synchronised output.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
    if (rst) begin
      meta_nxt = '0;
      q_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q = q_r;

endmodule

// ==== verif/sdbp_ctl_model.sv ====
// Controller model: drives the shared address, selects and write words on the link clock.
// Assumes the port marks the read slot as the cycle with echo_clock_out low.
`timescale 1ns/1ps
module sdbp_ctl_model
  import sdbp_pkg::*;
(
  // Link clock and slot marker.
  input wire logic link_clk,
  input wire logic echo_clock_out,
  // Pins toward the port, plus the hung flag for the bench.
  output logic [ADDR_W-1:0] addr_in,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [WORD_W-1:0] wdata_k,
  output logic [WORD_W-1:0] wdata_kn,
  output logic hung
);
  initial begin
    addr_in = RST_ADDR;
    rd_sel_n = 1'h1;
    wr_sel_n = 1'h1;
    wdata_k = RST_WORD;
    wdata_kn = RST_WORD;
    hung = 1'h0;
  end
  // A write slot then a read slot; a deselected slot still shows address and data.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] wa,
                      input logic [BURST_W-1:0] wd, input logic r, input logic [ADDR_W-1:0] ra);
    int n;
    n = 0;
    @(negedge link_clk);
    while (echo_clock_out !== 1'h0 && n < 8) begin
      @(negedge link_clk);
      n++;
    end
    hung = hung | (n == 8);
    addr_in = wa;
    wr_sel_n = !w;
    wdata_k = wd[17:0];
    wdata_kn = wd[35:18];
    @(negedge link_clk);
    addr_in = ra;
    rd_sel_n = !r;
    wr_sel_n = 1'h1;
    wdata_k = wd[53:36];
    wdata_kn = wd[71:54];
    @(negedge link_clk);
    // Released lines show the inverse so stale values cannot pass for held ones.
    rd_sel_n = 1'h1;
    addr_in = ~addr_in;
    wdata_k = ~wdata_k;
    wdata_kn = ~wdata_kn;
  endtask
endmodule

// ==== verif/sdbp_port_properties.sv ====
// Checker on the port's pins: echo clocks, read timing and the write-log flag.
// Assumes it is bound to sdbp_port and sees only its ports.
`timescale 1ns/1ps
module sdbp_port_properties
  import sdbp_pkg::*;
(
  // Clocks and reset.
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  // Read port.
  input wire logic rd_sel_n,
  input wire logic latency_select_pin,
  input wire logic [WORD_W-1:0] q_k,
  input wire logic [WORD_W-1:0] q_kn,
  input wire logic read_data_valid_out,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n,
  // Write log.
  input wire logic log_valid,
  input wire logic log_overflow
);
  echo_pair_a:
    assert property (@(posedge link_clk) disable iff (srst) echo_clock_out_n == !echo_clock_out)
    else $error("echo pair not complementary");
  echo_run_a:
    assert property (@(posedge link_clk) disable iff (srst)
      (!srst)[*6] |-> echo_clock_out != $past(echo_clock_out)) else $error("echo stalled");
  valid_cause_a:
    assert property (@(posedge link_clk) disable iff (srst) $rose(read_data_valid_out) |->
      (latency_select_pin ? !$past(rd_sel_n, 3) && $past(echo_clock_out, 3)
      : !$past(rd_sel_n, 2) && $past(echo_clock_out, 2))) else $error("valid without read");
  read_fast_a:
    assert property (@(posedge link_clk) disable iff (srst)
      !rd_sel_n && echo_clock_out && !latency_select_pin |-> ##2 read_data_valid_out[*2])
    else $error("short latency read missing");
  read_slow_a:
    assert property (@(posedge link_clk) disable iff (srst)
      !rd_sel_n && echo_clock_out && latency_select_pin |-> ##3 read_data_valid_out[*2])
    else $error("long latency read missing");
  q_hold_a:
    assert property (@(posedge link_clk) disable iff (srst)
      !read_data_valid_out && !$past(read_data_valid_out) |-> $stable(q_k) && $stable(q_kn))
    else $error("read data moved while idle");
  ovf_hold_a:
    assert property (@(posedge clk) disable iff (srst) log_overflow |=> log_overflow)
    else $error("overflow flag lost");
  ovf_cause_a:
    assert property (@(posedge clk) disable iff (srst) $rose(log_overflow) |-> $past(log_valid))
    else $error("overflow with log not full");
endmodule
bind sdbp_port sdbp_port_properties chk (.clk, .srst, .link_clk, .rd_sel_n, .latency_select_pin,
  .q_k, .q_kn, .read_data_valid_out, .echo_clock_out, .echo_clock_out_n, .log_valid, .log_overflow);

// ==== verif/tb_top.sv ====
// Testbench: random bursts through the port, latency modes, deselects and the write log.
// Assumes the controller model drives the link pins and expectations come from a bench copy.
`timescale 1ns/1ps
module tb_top
  import sdbp_pkg::*;
;
  logic clk, srst, link_clk, lat, log_ready, log_en, log_chk, hung;
  logic [ADDR_W-1:0] addr_in, log_addr;
  logic rd_sel_n, wr_sel_n, read_data_valid_out, echo_clock_out, echo_clock_out_n;
  logic [WORD_W-1:0] wdata_k, wdata_kn, q_k, q_kn;
  logic log_valid, log_room, log_overflow;
  logic [BURST_W-1:0] log_data;
  logic [BURST_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [31:0] seed = 32'h6E69AC57;
  sdbp_log_s exp_q [$];
  int miscompares = 0;
  int comparisons = 0;

  sdbp_port uut (.clk, .srst, .link_clk, .addr_in, .rd_sel_n, .wr_sel_n, .wdata_k, .wdata_kn,
    .latency_select_pin(lat), .q_k, .q_kn, .read_data_valid_out, .echo_clock_out,
    .echo_clock_out_n, .log_valid, .log_ready, .log_addr, .log_data, .log_room, .log_overflow);
  sdbp_ctl_model ctl (.link_clk, .echo_clock_out, .addr_in, .rd_sel_n, .wr_sel_n, .wdata_k,
    .wdata_kn, .hung);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] rnd();
    seed = lfsr(seed);
    return seed;
  endfunction
  // Expected {odd, even} words of one beat of a burst.
  function automatic logic [35:0] beat(input logic [BURST_W-1:0] b, input int i);
    return b[i*36 +: 36];
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rw(input logic w, input logic [ADDR_W-1:0] wa, input logic r,
                    input logic [ADDR_W-1:0] ra);
    logic [BURST_W-1:0] d;
    logic [BURST_W-1:0] e;
    d = BURST_W'({rnd(), rnd(), rnd()});
    if (w) begin
      mem[wa] = d;
      if (log_chk) exp_q.push_back('{wa, d});
    end
    // A read right behind the write of the same address sees the new burst.
    e = mem.exists(ra) ? mem[ra] : RST_BURST;
    ctl.xfer(w, wa, d, r, ra);
    chk(hung, 1'h0);
    repeat (32'(lat) + 1) @(negedge link_clk);
    for (int i = 0; i < 3; i++) begin
      chk(read_data_valid_out, r && i < 2);
      if (r && i < 2) chk({q_kn, q_k}, beat(e, i));
      @(negedge link_clk);
    end
  endtask

  task automatic wait_log();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || log_valid !== 1'h0) && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    srst = 1'h1;
    // Five cycles so that the link side also sees enough edges in reset.
    repeat (5) @(negedge clk);
    chk({q_kn, q_k, read_data_valid_out, echo_clock_out, echo_clock_out_n, log_valid,
      log_overflow}, {RST_WORD, RST_WORD, 1'h0, RST_ECHO, !RST_ECHO, 2'h0});
    srst = 1'h0;
    exp_q.delete();
    repeat (6) @(negedge link_clk);
  endtask

  always @(negedge clk) begin
    seed = lfsr(seed);
    log_ready = log_en && seed[0];
    if (log_chk && log_ready && log_valid === 1'h1) chk({log_addr, log_data}, exp_q.pop_front());
  end

  initial begin
    logic [ADDR_W-1:0] a [4];
    srst = 1'h1;
    lat = 1'h0;
    log_en = 1'h1;
    log_chk = 1'h1;
    for (int p = 0; p < 2; p++) begin
      lat = p[0];
      do_reset();
      for (int i = 0; i < 4; i++) a[i] = ADDR_W'(rnd());
      a[0] = p ? RST_ADDR : ~RST_ADDR;
      rw(1'h1, a[0], 1'h0, a[0]);
      for (int i = 1; i < 4; i++) rw(1'h1, a[i], 1'h1, a[i-1]);
      rw(1'h0, a[0], 1'h1, a[3]);
      rw(1'h0, a[1], 1'h1, a[0]);
      wait_log();
      if (p == 0) begin
        log_en = 1'h0;
        log_chk = 1'h0;
        repeat (34) rw(1'h1, ADDR_W'(rnd()), 1'h0, a[0]);
        repeat (10) @(negedge clk);
        chk({log_overflow, log_room}, 2'h2);
        log_en = 1'h1;
        wait_log();
        chk(log_overflow, 1'h1);
        log_chk = 1'h1;
      end
    end
    stop_test();
  end
endmodule
